// *** cbnf_pkg.sv ***
package cbnf_pkg;
    localparam int unsigned PC_W = 21;
    localparam int unsigned WORD_W = 16;
    localparam logic [7:0] OP_OVF_CLR = 8'he5;
    localparam logic [7:0] OP_ZERO_CLR = 8'he1;
    localparam logic [7:0] OP_NEG_CLR = 8'he7;
    localparam logic [PC_W-1:0] PC_STEP = 21'h000002;
    localparam logic [PC_W-1:0] PC_RESET = 21'h000000;
    localparam int unsigned OPC_HI = 15;
    localparam int unsigned OPC_LO = 8;
    localparam int unsigned OFS_HI = 7;
    localparam int unsigned OFS_LO = 0;
    localparam int unsigned FLAG_CARRY = 0;
    localparam int unsigned FLAG_ZERO = 2;
    localparam int unsigned FLAG_OVF = 3;
    localparam int unsigned FLAG_NEG = 4;
    localparam int unsigned FLAG_W = 5;
    typedef enum logic [1:0] {
        CBNF_KIND_NONE,
        CBNF_KIND_OVF,
        CBNF_KIND_ZERO,
        CBNF_KIND_NEG
    } cbnf_kind_t;
    typedef enum logic {
        CBNF_ST_RUN,
        CBNF_ST_FLUSH
    } cbnf_state_t;
endpackage : cbnf_pkg

// *** cbnf_dec_if.sv ***
`timescale 1ns/10ps
interface cbnf_dec_if;
    logic [cbnf_pkg::WORD_W-1:0] word;
    logic [cbnf_pkg::FLAG_W-1:0] flags;
    logic hit;
    logic take;
    logic signed [cbnf_pkg::PC_W-1:0] disp;
    modport dec (input word, input flags, output hit, output take, output disp);
    modport core (output word, output flags, input hit, input take, input disp);
endinterface : cbnf_dec_if

// *** cbnf_decode.sv ***
`timescale 1ns/10ps
module cbnf_decode (
    cbnf_dec_if.dec bus
);
    cbnf_pkg::cbnf_kind_t kind;
    logic [cbnf_pkg::OFS_HI:cbnf_pkg::OFS_LO] ofs;

    always_comb begin
        case (bus.word[cbnf_pkg::OPC_HI:cbnf_pkg::OPC_LO])
            cbnf_pkg::OP_OVF_CLR: kind = cbnf_pkg::CBNF_KIND_OVF;
            cbnf_pkg::OP_ZERO_CLR: kind = cbnf_pkg::CBNF_KIND_ZERO;
            cbnf_pkg::OP_NEG_CLR: kind = cbnf_pkg::CBNF_KIND_NEG;
            default: kind = cbnf_pkg::CBNF_KIND_NONE;
        endcase
    end

    always_comb begin
        case (kind)
            cbnf_pkg::CBNF_KIND_OVF: bus.take = ~bus.flags[cbnf_pkg::FLAG_OVF];
            cbnf_pkg::CBNF_KIND_ZERO: bus.take = ~bus.flags[cbnf_pkg::FLAG_ZERO];
            cbnf_pkg::CBNF_KIND_NEG: bus.take = ~bus.flags[cbnf_pkg::FLAG_NEG];
            default: bus.take = 1'h0;
        endcase
    end

    assign bus.hit = (kind != cbnf_pkg::CBNF_KIND_NONE);
    assign ofs = bus.word[cbnf_pkg::OFS_HI:cbnf_pkg::OFS_LO];
    // Sign-extended offset doubled to a byte displacement.
    assign bus.disp = {{(cbnf_pkg::PC_W-cbnf_pkg::OFS_HI-2){ofs[cbnf_pkg::OFS_HI]}}, ofs, 1'h0};
endmodule : cbnf_decode

// *** cbnf_branch.sv ***
`timescale 1ns/10ps
module cbnf_branch (
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic instr_valid_i,
    input wire logic [cbnf_pkg::WORD_W-1:0] instr_i,
    input wire logic [cbnf_pkg::PC_W-1:0] instr_addr_i,
    input wire logic [cbnf_pkg::FLAG_W-1:0] status_i,
    output logic branch_hit_o,
    output logic pc_write_o,
    output logic [cbnf_pkg::PC_W-1:0] pc_target_o,
    output logic flush_o,
    output logic busy_o,
    output logic done_o,
    output logic [cbnf_pkg::FLAG_W-1:0] status_o
);
    ////////////////////////////////////////////////////////////////////////
    cbnf_dec_if dec_bus ();
    cbnf_pkg::cbnf_state_t state_q;
    cbnf_pkg::cbnf_state_t state_d;
    logic accept;
    logic take_now;
    logic skip_now;
    logic [cbnf_pkg::PC_W-1:0] seq_addr;
    logic [cbnf_pkg::PC_W-1:0] jump_addr;
    logic hit_q;
    logic hit_d;
    logic pc_wr_q;
    logic pc_wr_d;
    logic [cbnf_pkg::PC_W-1:0] target_q;
    logic [cbnf_pkg::PC_W-1:0] target_d;
    logic flush_q;
    logic flush_d;
    logic busy_q;
    logic busy_d;
    logic done_q;
    logic done_d;
    logic [cbnf_pkg::FLAG_W-1:0] status_q;
    logic [cbnf_pkg::FLAG_W-1:0] status_d;

    ////////////////////////////////////////////////////////////////////////
    // The decoder sees the offered word and the live status flags.
    assign dec_bus.word = instr_i;
    assign dec_bus.flags = status_i;

    cbnf_decode u_decode (
        .bus(dec_bus)
    );

    ////////////////////////////////////////////////////////////////////////
    // A new word is accepted only outside the no-operation cycle.
    assign accept = instr_valid_i && (state_q == cbnf_pkg::CBNF_ST_RUN);
    assign take_now = accept && dec_bus.hit && dec_bus.take;
    assign skip_now = accept && dec_bus.hit && !dec_bus.take;

    // The fall-through address is the incremented program counter.
    assign seq_addr = instr_addr_i + cbnf_pkg::PC_STEP;
    assign jump_addr = seq_addr + dec_bus.disp;

    ////////////////////////////////////////////////////////////////////////
    // A taken branch spends one extra cycle in the no-operation state.
    always_comb begin
        case (state_q)
            cbnf_pkg::CBNF_ST_RUN: begin
                if (take_now) begin
                    state_d = cbnf_pkg::CBNF_ST_FLUSH;
                end else begin
                    state_d = cbnf_pkg::CBNF_ST_RUN;
                end
            end
            cbnf_pkg::CBNF_ST_FLUSH: state_d = cbnf_pkg::CBNF_ST_RUN;
            default: state_d = cbnf_pkg::CBNF_ST_RUN;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            state_q <= cbnf_pkg::CBNF_ST_RUN;
        end else begin
            state_q <= state_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Pulse for an accepted word that is one of the three branches.
    always_comb begin
        if (accept && dec_bus.hit) begin
            hit_d = 1'h1;
        end else begin
            hit_d = 1'h0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            hit_q <= 1'h0;
        end else begin
            hit_q <= hit_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Program counter write strobe, raised only for a taken branch.
    always_comb begin
        if (take_now) begin
            pc_wr_d = 1'h1;
        end else begin
            pc_wr_d = 1'h0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            pc_wr_q <= 1'h0;
        end else begin
            pc_wr_q <= pc_wr_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Target address, held while no word is accepted.
    always_comb begin
        if (take_now) begin
            target_d = jump_addr;
        end else if (accept) begin
            target_d = seq_addr;
        end else begin
            target_d = target_q;
        end
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            target_q <= cbnf_pkg::PC_RESET;
        end else begin
            target_q <= target_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Marks the no-operation second cycle of a taken branch.
    always_comb begin
        if (state_d == cbnf_pkg::CBNF_ST_FLUSH) begin
            flush_d = 1'h1;
        end else begin
            flush_d = 1'h0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            flush_q <= 1'h0;
        end else begin
            flush_q <= flush_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Tells the fetch side that an offered word is ignored this cycle.
    always_comb begin
        if (state_d == cbnf_pkg::CBNF_ST_FLUSH) begin
            busy_d = 1'h1;
        end else begin
            busy_d = 1'h0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            busy_q <= 1'h0;
        end else begin
            busy_q <= busy_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Completion pulse after one cycle, or after two when taken.
    always_comb begin
        if (skip_now) begin
            done_d = 1'h1;
        end else if (state_q == cbnf_pkg::CBNF_ST_FLUSH) begin
            done_d = 1'h1;
        end else begin
            done_d = 1'h0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            done_q <= 1'h0;
        end else begin
            done_q <= done_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Status passes through unchanged by these branches.
    always_comb begin
        status_d = status_i;
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            status_q <= '0;
        end else begin
            status_q <= status_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Every output comes straight from its register.
    assign branch_hit_o = hit_q;
    assign pc_write_o = pc_wr_q;
    assign pc_target_o = target_q;
    assign flush_o = flush_q;
    assign busy_o = busy_q;
    assign done_o = done_q;
    assign status_o = status_q;
endmodule : cbnf_branch

// *** cbnf_branch_sva.sv ***
`timescale 1ns/10ps
module cbnf_branch_sva (
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic instr_valid_i,
    input wire logic [cbnf_pkg::WORD_W-1:0] instr_i,
    input wire logic [cbnf_pkg::FLAG_W-1:0] status_i,
    input wire logic branch_hit_o,
    input wire logic pc_write_o,
    input wire logic busy_o,
    input wire logic done_o,
    input wire logic [cbnf_pkg::FLAG_W-1:0] status_o
);
    default clocking @(posedge clk_i);
    endclocking
    default disable iff (reset_i);
    ovf_take_a: assert property (instr_valid_i && !busy_o && instr_i[15:8] == 8'he5
        |=> pc_write_o == !$past(status_i[3])) else $error("overflow branch wrong");
    zero_take_a: assert property (instr_valid_i && !busy_o && instr_i[15:8] == 8'he1
        |=> pc_write_o == !$past(status_i[2])) else $error("zero branch wrong");
    neg_take_a: assert property (instr_valid_i && !busy_o && instr_i[15:8] == 8'he7
        |=> pc_write_o == !$past(status_i[4])) else $error("negative branch wrong");
    taken_len_a: assert property (pc_write_o |-> busy_o ##1 (done_o && !busy_o))
        else $error("taken branch length wrong");
    skip_len_a: assert property (branch_hit_o && !pc_write_o |-> done_o && !busy_o)
        else $error("skipped branch wrong");
    flags_kept_a: assert property (!$past(reset_i) |-> status_o == $past(status_i))
        else $error("flags changed");
endmodule : cbnf_branch_sva
bind cbnf_branch cbnf_branch_sva i_cbnf_branch_sva (.clk_i, .reset_i, .instr_valid_i, .instr_i, .status_i,
    .branch_hit_o, .pc_write_o, .busy_o, .done_o, .status_o);

// *** tb_top.sv ***
`timescale 1ns/10ps
module tb_top;
    logic clk_i = 0;
    logic reset_i = 1;
    logic instr_valid_i = 0;
    logic [15:0] instr_i = 16'h0000;
    logic [20:0] instr_addr_i = 21'h000000;
    logic [4:0] status_i = 5'h00;
    logic hit, wr, flush, busy, done;
    logic [20:0] tgt;
    logic [4:0] st;
    int n_fail = 0;
    int checked = 0;
    cbnf_branch i_cbnf_branch (.clk_i, .reset_i, .instr_valid_i, .instr_i, .instr_addr_i, .status_i,
        .branch_hit_o(hit), .pc_write_o(wr), .pc_target_o(tgt), .flush_o(flush), .busy_o(busy),
        .done_o(done), .status_o(st));
    initial forever #2.5 clk_i = ~clk_i;
    task automatic cmp(input string nm, input logic [20:0] e, input logic [20:0] g);
        checked++;
        if (g !== e) begin
            n_fail++;
            $display("wrong value %s exp %h got %h", nm, e, g);
        end
    endtask : cmp
    task automatic exec(input logic [15:0] w, input logic [4:0] f, input logic hb, input logic tk);
        logic [20:0] t;
        t = 21'h001002 + (tk ? {{12{w[7]}}, w[7:0], 1'b0} : 21'h000000);
        instr_i = w;
        status_i = f;
        instr_addr_i = 21'h001000;
        instr_valid_i = 1'b1;
        @(posedge clk_i);
        #1;
        cmp("hit", hb, hit);
        cmp("write", tk, wr);
        cmp("target", t, tgt);
        cmp("done", hb && !tk, done);
        cmp("flush", tk, flush);
        cmp("busy", tk, busy);
        cmp("flags", f, st);
        if (tk) begin
            instr_i = 16'he500;
            status_i = 5'h00;
            @(posedge clk_i);
            #1;
            cmp("done2", 1'h1, done);
            cmp("refused", 1'h0, hit);
            cmp("flush2", 1'h0, flush);
            cmp("hold", t, tgt);
        end
    endtask : exec
    task automatic t_branches;
        logic [7:0] op;
        int b;
        for (int i = 0; i < 12; i++) begin
            op = i % 3 == 0 ? cbnf_pkg::OP_OVF_CLR : i % 3 == 1 ? cbnf_pkg::OP_ZERO_CLR : cbnf_pkg::OP_NEG_CLR;
            b = i % 3 == 0 ? cbnf_pkg::FLAG_OVF : i % 3 == 1 ? cbnf_pkg::FLAG_ZERO : cbnf_pkg::FLAG_NEG;
            exec({op, i < 6 ? 8'h80 : 8'h7f}, i[0] ? ~(5'h01 << b) : 5'h01 << b, 1'b1, i[0]);
        end
    endtask : t_branches
    task automatic t_other;
        exec(16'h0f12, 5'h00, 1'b0, 1'b0);
    endtask : t_other
    task automatic print_verdict;
        if (n_fail == 0 && checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : print_verdict
    initial begin
        repeat (4) @(posedge clk_i);
        #1;
        reset_i = 0;
        @(posedge clk_i);
        #1;
        t_branches();
        t_other();
        instr_valid_i = 1'b0;
        @(posedge clk_i);
        print_verdict();
    end
endmodule : tb_top
